/* File: pkg/pvp_pkg.sv */
package pvp_pkg;

   // Main configuration word, bit 0 at the bottom.
   typedef struct packed {
      logic [2:0]  rsv_31_29;
      logic [1:0]  sample_format;
      logic [3:0]  active_slot;
      logic [1:0]  master_rate;
      logic [7:0]  rsv_20_13;
      logic        long_sync_16;
      logic        fast_reference_synth_select;
      logic        mute;
      logic        isdn_timing_select;
      logic        frame_pulse_hold_off;
      logic        output_release_late_select;
      logic        output_release_enable;
      logic        lsb_first;
      logic        pad_with_sign_select;
      logic        rsv_3;
      logic        short_sync;
      logic        slave_mode;
      logic        rsv_0;
   } pvp_main_cfg_s;

   // Low-jitter configuration word.
   typedef struct packed {
      logic [7:0]  frame_divider;
      logic [7:0]  synth_step_value;
      logic [2:0]  rsv_15_13;
      logic [12:0] synth_counter_limit;
   } pvp_jit_cfg_s;

   // One sample for each of the two channels of a frame.
   typedef struct packed {
      logic [15:0] ch1;
      logic [15:0] ch0;
   } pvp_pair_s;

   localparam logic [31:0] PVP_MAIN_RESET  = 32'h00800000;
   localparam logic [31:0] PVP_JIT_RESET   = 32'h08080177;
   localparam logic        PVP_SEL_MAIN    = 1'h0;
   localparam logic        PVP_SEL_JIT     = 1'h1;

   localparam logic [1:0]  PVP_RATE_128    = 2'h1;
   localparam logic [1:0]  PVP_RATE_256    = 2'h0;
   localparam logic [1:0]  PVP_RATE_512    = 2'h2;

   localparam logic [1:0]  PVP_FMT_13      = 2'h0;
   localparam logic [1:0]  PVP_FMT_16      = 2'h1;
   localparam logic [1:0]  PVP_FMT_8W      = 2'h2;
   localparam logic [1:0]  PVP_FMT_8N      = 2'h3;

   // Slow reference: toggle rate is 4 MHz times step over 125.
   localparam logic [13:0] PVP_SLOW_LIMIT  = 14'h007D;
   localparam logic [7:0]  PVP_STEP_128    = 8'h08;
   localparam logic [7:0]  PVP_STEP_256    = 8'h10;
   localparam logic [7:0]  PVP_STEP_512    = 8'h20;
   localparam logic [10:0] PVP_FRAME_128   = 11'h010;
   localparam logic [10:0] PVP_FRAME_256   = 11'h020;
   localparam logic [10:0] PVP_FRAME_512   = 11'h040;

   localparam logic [10:0] PVP_SYNC_LEN_8  = 11'h008;
   localparam logic [10:0] PVP_SYNC_LEN_16 = 11'h010;
   localparam logic [5:0]  PVP_IDX_IDLE    = 6'h3F;
   localparam logic [3:0]  PVP_LAST_8      = 4'h7;
   localparam logic [3:0]  PVP_LAST_16     = 4'hF;

endpackage : pvp_pkg

/* File: logic/pvp_clock_gen.sv */
`timescale 1ns/100ps
module pvp_clock_gen (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        slow_tick_in,
   input  wire logic        fast_tick_in,
   input  wire logic        fast_sel_in,
   input  wire logic [1:0]  rate_sel_in,
   input  wire logic [12:0] limit_in,
   input  wire logic [7:0]  step_in,
   input  wire logic [7:0]  frame_div_in,
   input  wire logic        long16_in,
   input  wire logic        short_sync_in,
   output logic             bit_clk_out,
   output logic             frame_sync_out
);

   logic [12:0] acc;
   logic [12:0] next_acc;
   logic        bclk;
   logic        next_bclk;
   logic [10:0] fcnt;
   logic [10:0] next_fcnt;
   logic        sync;
   logic        next_sync;
   logic        tick;
   logic [13:0] lim;
   logic [13:0] sum;
   logic [7:0]  stp;
   logic [10:0] flen;
   logic [10:0] slen;

   // Phase accumulator: each reference tick adds the step, and reaching or passing the limit toggles the bit clock.
   // The rate is only as even as the ticks; a step above the limit gives one toggle per tick.
   always_comb begin
      tick = fast_sel_in ? fast_tick_in : slow_tick_in;
      lim  = fast_sel_in ? {1'h0, limit_in} : pvp_pkg::PVP_SLOW_LIMIT;
      if (fast_sel_in) begin
         stp  = step_in;
         flen = {frame_div_in, 3'h0};
      end else begin
         unique case (rate_sel_in)
            pvp_pkg::PVP_RATE_128: begin
               stp  = pvp_pkg::PVP_STEP_128;
               flen = pvp_pkg::PVP_FRAME_128;
            end
            pvp_pkg::PVP_RATE_512: begin
               stp  = pvp_pkg::PVP_STEP_512;
               flen = pvp_pkg::PVP_FRAME_512;
            end
            default: begin
               stp  = pvp_pkg::PVP_STEP_256;
               flen = pvp_pkg::PVP_FRAME_256;
            end
         endcase
      end
      slen = (fast_sel_in && long16_in) ? pvp_pkg::PVP_SYNC_LEN_16 : pvp_pkg::PVP_SYNC_LEN_8;
      sum       = {1'h0, acc} + {6'h00, stp};
      next_acc  = acc;
      next_bclk = bclk;
      next_fcnt = fcnt;
      next_sync = sync;
      if (tick) begin
         if (sum >= lim) begin
            next_acc  = 13'(sum - lim);
            next_bclk = !bclk;
            // Sync moves only with a rising bit clock so the far end sees it settled at the falling edge.
            if (!bclk) begin
               // Wrapping at or past the end keeps a frame shortened by a rate change from running the full count.
               next_fcnt = (fcnt >= 11'(flen - 11'h001)) ? 11'h000 : 11'(fcnt + 11'h001);
               if (short_sync_in) begin
                  next_sync = (next_fcnt == 11'(flen - 11'h001));
               end else begin
                  next_sync = (next_fcnt < slen);
               end
            end
         end else begin
            next_acc = sum[12:0];
         end
      end
   end

   // Registers of the generator.
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc  <= 13'h0000;
         bclk <= 1'h0;
         fcnt <= 11'h000;
         sync <= 1'h0;
      end else begin
         acc  <= next_acc;
         bclk <= next_bclk;
         fcnt <= next_fcnt;
         sync <= next_sync;
      end
   end

   assign bit_clk_out    = bclk;
   assign frame_sync_out = sync;

endmodule : pvp_clock_gen

/* File: logic/pvp_bit_map.sv */
`timescale 1ns/100ps
module pvp_bit_map (
   input  wire logic [3:0]  idx_in,
   input  wire logic [1:0]  format_in,
   input  wire logic        lsb_first_in,
   input  wire logic        pad_sign_in,
   input  wire logic [15:0] sample_in,
   output logic [3:0]       pos_out,
   output logic             tx_bit_out
);

   logic [15:0] word;
   logic [3:0]  last;

   // The sample is widened to the slot, so sign or zero fill lands in the upper unused bits.
   always_comb begin
      unique case (format_in)
         pvp_pkg::PVP_FMT_13: word = pad_sign_in ? {{3{sample_in[12]}}, sample_in[12:0]} : {3'h0, sample_in[12:0]};
         pvp_pkg::PVP_FMT_16: word = sample_in;
         pvp_pkg::PVP_FMT_8W: word = pad_sign_in ? {{8{sample_in[7]}}, sample_in[7:0]} : {8'h00, sample_in[7:0]};
         pvp_pkg::PVP_FMT_8N: word = {8'h00, sample_in[7:0]};
      endcase
      last       = (format_in == pvp_pkg::PVP_FMT_8N) ? pvp_pkg::PVP_LAST_8 : pvp_pkg::PVP_LAST_16;
      pos_out    = lsb_first_in ? idx_in : 4'(last - idx_in);
      tx_bit_out = word[pos_out];
   end

endmodule : pvp_bit_map

/* File: logic/pvp_voice_port.sv */
`timescale 1ns/100ps
module pvp_voice_port (
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   input  wire logic              cfg_wr_in,
   input  wire logic              cfg_sel_in,
   input  wire logic [31:0]       cfg_wdata_in,
   output logic [31:0]            main_config_out,
   output logic [31:0]            low_jitter_config_out,
   input  wire logic              slow_tick_in,
   input  wire logic              fast_tick_in,
   input  wire logic              pcm_clk_in,
   output logic                   pcm_clk_out,
   output logic                   pcm_clk_oe_out,
   input  wire logic              pcm_sync_in,
   output logic                   pcm_sync_out,
   output logic                   pcm_sync_oe_out,
   input  wire logic              pcm_data_in,
   output logic                   pcm_data_out,
   output logic                   pcm_data_oe_out,
   input  wire pvp_pkg::pvp_pair_s tx_sample_in,
   output logic                   tx_take_out,
   output pvp_pkg::pvp_pair_s     rx_sample_out,
   output logic                   rx_valid_out,
   output logic                   frame_start_out
);

   pvp_pkg::pvp_main_cfg_s main_cfg;
   pvp_pkg::pvp_main_cfg_s next_main_cfg;
   pvp_pkg::pvp_jit_cfg_s  jit_cfg;
   pvp_pkg::pvp_jit_cfg_s  next_jit_cfg;

   logic              gen_clk;
   logic              gen_sync;
   logic              line_clk;
   logic              line_sync;
   logic              clk_q;
   logic              next_clk_q;
   logic              sync_q;
   logic              next_sync_q;
   logic              rise;
   logic              fall;
   logic              start;

   logic [5:0]        idx;
   logic [5:0]        next_idx;
   logic [5:0]        l_idx;
   logic [1:0]        eff_fmt;
   logic              eff8;
   logic [2:0]        slot;
   logic [3:0]        bit_in_slot;
   logic              active;
   logic              last_bit;
   logic              next_active;
   logic [2:0]        l_slot;
   logic [3:0]        l_bit;
   logic              l_active;
   logic [3:0]        last_code;

   pvp_pkg::pvp_pair_s tx_hold;
   pvp_pkg::pvp_pair_s next_tx_hold;
   pvp_pkg::pvp_pair_s tx_sel;
   pvp_pkg::pvp_pair_s rx_shift;
   pvp_pkg::pvp_pair_s next_rx_shift;
   pvp_pkg::pvp_pair_s rx_word;
   pvp_pkg::pvp_pair_s next_rx_word;
   logic              rx_valid;
   logic              next_rx_valid;
   logic              out_bit;
   logic              next_out_bit;
   logic              out_en;
   logic              next_out_en;
   logic [15:0]       tx_slot_sample;
   logic              map_tx_bit;
   logic [3:0]        rx_pos;

   // Configuration words: software loads one word at a time, and everything is read back as stored.
   always_comb begin
      next_main_cfg = main_cfg;
      next_jit_cfg  = jit_cfg;
      if (cfg_wr_in) begin
         if (cfg_sel_in == pvp_pkg::PVP_SEL_MAIN) begin
            next_main_cfg = pvp_pkg::pvp_main_cfg_s'(cfg_wdata_in);
         end else begin
            next_jit_cfg = pvp_pkg::pvp_jit_cfg_s'(cfg_wdata_in);
         end
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         main_cfg <= pvp_pkg::pvp_main_cfg_s'(pvp_pkg::PVP_MAIN_RESET);
         jit_cfg  <= pvp_pkg::pvp_jit_cfg_s'(pvp_pkg::PVP_JIT_RESET);
      end else begin
         main_cfg <= next_main_cfg;
         jit_cfg  <= next_jit_cfg;
      end
   end

   assign main_config_out       = main_cfg;
   assign low_jitter_config_out = jit_cfg;

   // Master timing source; it runs in slave mode too, but its levels are then ignored.
   pvp_clock_gen u_clock_gen (
      .core_clk_in    (core_clk_in),
      .rst_in         (rst_in),
      .slow_tick_in   (slow_tick_in),
      .fast_tick_in   (fast_tick_in),
      .fast_sel_in    (main_cfg.fast_reference_synth_select),
      .rate_sel_in    (main_cfg.master_rate),
      .limit_in       (jit_cfg.synth_counter_limit),
      .step_in        (jit_cfg.synth_step_value),
      .frame_div_in   (jit_cfg.frame_divider),
      .long16_in      (main_cfg.long_sync_16),
      .short_sync_in  (main_cfg.short_sync & ~main_cfg.isdn_timing_select),
      .bit_clk_out    (gen_clk),
      .frame_sync_out (gen_sync)
   );

   // Pins: a master drives clock and sync, a slave leaves both to the far end.
   assign pcm_clk_out     = gen_clk;
   assign pcm_clk_oe_out  = !main_cfg.slave_mode;
   assign pcm_sync_out    = gen_sync & !main_cfg.frame_pulse_hold_off;
   assign pcm_sync_oe_out = !main_cfg.slave_mode;
   assign pcm_data_out    = out_bit;
   assign pcm_data_oe_out = out_en;

   // One framing path serves both roles; only the source of clock and sync differs.
   // Internal frames keep running while the sync pin is held off, so the codec can wake cleanly.
   always_comb begin
      line_clk  = main_cfg.slave_mode ? pcm_clk_in : gen_clk;
      line_sync = main_cfg.slave_mode ? pcm_sync_in : gen_sync;
      rise      = line_clk && !clk_q;
      fall      = !line_clk && clk_q;
      next_clk_q  = line_clk;
      next_sync_q = rise ? line_sync : sync_q;
      if (main_cfg.short_sync && !main_cfg.isdn_timing_select) begin
         start = rise && sync_q && !line_sync;
      end else begin
         start = rise && !sync_q && line_sync;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_q  <= 1'h0;
         sync_q <= 1'h0;
      end else begin
         clk_q  <= next_clk_q;
         sync_q <= next_sync_q;
      end
   end

   // Slot geometry for the bit in flight (idx) and for the bit about to launch (l_idx).
   // ISDN timing carries two 8-bit B channels in the first two 8-clock slots.
   always_comb begin
      eff_fmt   = main_cfg.isdn_timing_select ? pvp_pkg::PVP_FMT_8N : main_cfg.sample_format;
      eff8      = (eff_fmt == pvp_pkg::PVP_FMT_8N);
      last_code = eff8 ? pvp_pkg::PVP_LAST_8 : pvp_pkg::PVP_LAST_16;
      l_idx     = start ? 6'h00 : ((idx == pvp_pkg::PVP_IDX_IDLE) ? idx : 6'(idx + 6'h01));
      slot        = eff8 ? idx[5:3] : {1'h0, idx[5:4]};
      bit_in_slot = eff8 ? {1'h0, idx[2:0]} : idx[3:0];
      l_slot      = eff8 ? l_idx[5:3] : {1'h0, l_idx[5:4]};
      l_bit       = eff8 ? {1'h0, l_idx[2:0]} : l_idx[3:0];
      active      = (idx != pvp_pkg::PVP_IDX_IDLE) &&
                    ((slot == 3'h0) || (main_cfg.isdn_timing_select && (slot == 3'h1)));
      l_active    = (l_idx != pvp_pkg::PVP_IDX_IDLE) &&
                    ((l_slot == 3'h0) || (main_cfg.isdn_timing_select && (l_slot == 3'h1)));
      last_bit    = (bit_in_slot == last_code);
      next_active = (slot == 3'h0) && main_cfg.isdn_timing_select;
      tx_sel         = start ? tx_sample_in : tx_hold;
      tx_slot_sample = (l_slot == 3'h1) ? tx_sel.ch1 : tx_sel.ch0;
   end

   // Transmit mapping for the launching bit.
   pvp_bit_map u_tx_map (
      .idx_in       (l_bit),
      .format_in    (eff_fmt),
      .lsb_first_in (main_cfg.lsb_first),
      .pad_sign_in  (main_cfg.pad_with_sign_select),
      .sample_in    (tx_slot_sample),
      .pos_out      (),
      .tx_bit_out   (map_tx_bit)
   );

   // Receive mapping gives the sample bit that the incoming bit belongs to.
   pvp_bit_map u_rx_map (
      .idx_in       (bit_in_slot),
      .format_in    (eff_fmt),
      .lsb_first_in (main_cfg.lsb_first),
      .pad_sign_in  (main_cfg.pad_with_sign_select),
      .sample_in    (16'h0000),
      .pos_out      (rx_pos),
      .tx_bit_out   ()
   );

   // Serial engine: launch on the rising bit clock, sample on the falling one.
   always_comb begin
      next_idx      = idx;
      next_tx_hold  = tx_hold;
      next_rx_shift = rx_shift;
      next_rx_word  = rx_word;
      next_rx_valid = 1'h0;
      next_out_bit  = out_bit;
      next_out_en   = out_en;
      if (rise) begin
         next_idx = l_idx;
         if (start) begin
            next_tx_hold = tx_sample_in;
         end
         next_out_bit = (l_active && !main_cfg.mute) ? map_tx_bit : 1'h0;
      end
      if (fall && active) begin
         if (slot == 3'h1) begin
            next_rx_shift.ch1[rx_pos] = pcm_data_in;
         end else begin
            next_rx_shift.ch0[rx_pos] = pcm_data_in;
         end
         // The pair is published once the last active slot of the frame is complete.
         if (last_bit && !next_active) begin
            next_rx_word  = next_rx_shift;
            next_rx_valid = 1'h1;
         end
      end
      // Release control: with release off the pin is always driven, idle bits read as zero.
      if (!main_cfg.output_release_enable) begin
         next_out_en = 1'h1;
      end else if (rise) begin
         if (l_active) begin
            next_out_en = 1'h1;
         end else if (main_cfg.output_release_late_select) begin
            next_out_en = 1'h0;
         end
      end else if (fall && !main_cfg.output_release_late_select) begin
         if (active && last_bit && !next_active) begin
            next_out_en = 1'h0;
         end
      end
      if (main_cfg.mute) begin
         next_out_bit = 1'h0;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         idx      <= pvp_pkg::PVP_IDX_IDLE;
         tx_hold  <= '0;
         rx_shift <= '0;
         rx_word  <= '0;
         rx_valid <= 1'h0;
         out_bit  <= 1'h0;
         out_en   <= 1'h0;
      end else begin
         idx      <= next_idx;
         tx_hold  <= next_tx_hold;
         rx_shift <= next_rx_shift;
         rx_word  <= next_rx_word;
         rx_valid <= next_rx_valid;
         out_bit  <= next_out_bit;
         out_en   <= next_out_en;
      end
   end

   // The user side sees the sample being taken in the same cycle as the frame start.
   assign tx_take_out     = start;
   assign frame_start_out = start;
   assign rx_sample_out   = rx_word;
   assign rx_valid_out    = rx_valid;

endmodule : pvp_voice_port

/* File: verif/pvp_voice_port_sva.sv */
`timescale 1ns/100ps
// Port-level checks of the voice port, bound to its top module.
module pvp_voice_port_sva (
   input wire logic        core_clk_in,
   input wire logic        rst_in,
   input wire logic        cfg_wr_in,
   input wire logic        cfg_sel_in,
   input wire logic [31:0] cfg_wdata_in,
   input wire logic [31:0] main_config_out,
   input wire logic [31:0] low_jitter_config_out,
   input wire logic        pcm_clk_out,
   input wire logic        pcm_clk_oe_out,
   input wire logic        pcm_sync_out,
   input wire logic        pcm_data_out,
   input wire logic        pcm_data_oe_out,
   input wire logic        rx_valid_out,
   input wire logic        frame_start_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic [4:0] falls;
   logic [4:0] next_falls;
   logic       clk_q;
   logic       next_clk_q;
   wire logic  mute = main_config_out[10];
   wire logic  m = !main_config_out[1];
   // Counts clock falls under a high sync; falls, because a sync lagging the clock would add a rise.
   always_comb begin
      next_clk_q = pcm_clk_out;
      next_falls = pcm_sync_out ? falls + {4'h0, clk_q & !pcm_clk_out} : 5'h00;
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         falls <= 5'h00;
         clk_q <= 1'h0;
      end else begin
         falls <= next_falls;
         clk_q <= next_clk_q;
      end
   end
   AST_MAIN_WR: assert property (cfg_wr_in && !cfg_sel_in |=> main_config_out == $past(cfg_wdata_in))
      else $error("main word not stored");
   AST_JIT_WR: assert property (cfg_wr_in && cfg_sel_in |=> low_jitter_config_out == $past(cfg_wdata_in))
      else $error("low-jitter word not stored");
   AST_NO_WR: assert property (!cfg_wr_in |=> $stable(main_config_out) && $stable(low_jitter_config_out))
      else $error("config changed unwritten");
   AST_ROLE: assert property ($stable(main_config_out) |-> pcm_clk_oe_out == m)
      else $error("clock enable wrong for role");
   AST_HOLD_OFF: assert property (m && main_config_out[8] |-> !pcm_sync_out)
      else $error("sync not held off");
   AST_MUTE: assert property (mute && $past(mute) |-> !pcm_data_out)
      else $error("muted output not zero");
   AST_VALID: assert property (rx_valid_out |=> !rx_valid_out)
      else $error("receive valid too long");
   AST_SYNC_LEN: assert property (m |-> falls <= (main_config_out[12] && main_config_out[11] ? 5'h10 : 5'h08))
      else $error("sync pulse too long");
   AST_KEEP_OE: assert property (!cfg_wr_in && !main_config_out[6] |=> pcm_data_oe_out)
      else $error("output released while release is off");
   cover property (frame_start_out && main_config_out[9]);
   cover property (rx_valid_out && !m);
   cover property ($fell(pcm_data_oe_out));
endmodule : pvp_voice_port_sva

bind pvp_voice_port pvp_voice_port_sva pvp_voice_port_sva_i (.*);

/* File: verif/pvp_codec_model.sv */
`timescale 1ns/100ps
// Far-end codec; it also clocks the link while the port has released the clock pin.
module pvp_codec_model (
   input  wire logic        core_clk_in,
   input  wire logic        dev_clk_in,
   input  wire logic        dev_sync_in,
   input  wire logic        dev_oe_in,
   input  wire logic        dev_data_in,
   input  wire logic [5:0]  nbits_in,
   output logic             line_clk_out,
   output logic             line_sync_out,
   output logic             data_out,
   output logic [15:0]      cap_out
);
   localparam logic [15:0] RX_WORD = 16'hC3A5;
   logic [7:0]  div = 8'h00;
   logic        own_clk = 1'b0;
   logic [5:0]  idx = 6'h3F;
   logic        sync_q = 1'b0;
   logic        clk_q = 1'b0;
   // Own clock: 8 core cycles a bit, 32 bits a frame, sync high for the first 8 bits.
   always @(posedge core_clk_in) begin
      div <= dev_oe_in ? 8'h00 : div + 8'h01;
      own_clk <= !dev_oe_in && div[2];
   end
   assign line_clk_out = dev_oe_in ? dev_clk_in : own_clk;
   assign line_sync_out = dev_oe_in ? dev_sync_in : div[7:6] == 2'h0;
   // Sends RX_WORD from each sync rise; past the slot the pin drops to its pull-down level.
   // Line edges are seen on the core clock, so a sync and a clock that move on one edge cannot race.
   always @(posedge core_clk_in) begin
      clk_q <= line_clk_out;
      if (line_clk_out && !clk_q) begin
         idx <= (line_sync_out && !sync_q) ? 6'h00 : idx + {5'h00, idx != 6'h3F};
         sync_q <= line_sync_out;
      end
      // Captures the port's output at each fall within the slot.
      if (!line_clk_out && clk_q && idx < nbits_in) cap_out <= {cap_out[14:0], dev_data_in};
   end
   assign data_out = idx < nbits_in ? RX_WORD[4'(nbits_in - idx - 6'h01)] : 1'b0;
endmodule : pvp_codec_model

/* File: verif/pvp_voice_port_tb_top.sv */
`timescale 1ns/100ps
// Drives the config port and checks whole frames against the codec model.
module pvp_voice_port_tb_top;
   logic               core_clk_in = 1'b0;
   logic               rst_in = 1'b1;
   logic               cfg_wr_in = 1'b0;
   logic               cfg_sel_in = 1'b0;
   logic [31:0]        cfg_wdata_in = 32'h00000000;
   logic               slow_tick_in = 1'b1;
   logic               fast_tick_in = 1'b1;
   pvp_pkg::pvp_pair_s tx_sample_in = 32'h5A3C9B71;
   pvp_pkg::pvp_pair_s rx_sample_out;
   logic [31:0]        main_config_out, low_jitter_config_out;
   logic               pcm_clk_in, pcm_clk_out, pcm_clk_oe_out, pcm_sync_in, pcm_sync_out, pcm_sync_oe_out;
   logic               pcm_data_in, pcm_data_out, pcm_data_oe_out, tx_take_out, rx_valid_out, frame_start_out;
   logic [15:0]        cap;
   logic [5:0]         nbits = 6'h10;
   logic               sync_lvl;
   int                 fails = 0, tests_run = 0, cyc = 0;
   // The data pin has a pull-down, so a released line reads low.
   wire logic          dline = pcm_data_oe_out ? pcm_data_out : 1'b0;

   pvp_voice_port pvp_voice_port_i (.*);
   pvp_codec_model pvp_codec_model_i (.core_clk_in(core_clk_in), .dev_clk_in(pcm_clk_out),
      .dev_sync_in(pcm_sync_out), .dev_oe_in(pcm_clk_oe_out), .dev_data_in(dline), .nbits_in(nbits),
      .line_clk_out(pcm_clk_in), .line_sync_out(pcm_sync_in), .data_out(pcm_data_in), .cap_out(cap));

   initial forever #50 core_clk_in = ~core_clk_in;

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // The run needs some 20000 cycles, so twice that means a hang.
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check_eq

   task automatic wr_cfg(input logic sel, input logic [31:0] data);
      @(posedge core_clk_in);
      cfg_wr_in <= 1'b1;
      cfg_sel_in <= sel;
      cfg_wdata_in <= data;
      @(posedge core_clk_in);
      cfg_wr_in <= 1'b0;
   endtask : wr_cfg

   function automatic logic [15:0] rev16(input logic [15:0] v);
      return {<<{v}};
   endfunction : rev16

   // The first frame may straddle the write, so only the third start is judged.
   task automatic scen(input logic [31:0] cfg, input int exp_gap, input logic [15:0] e_cap, e_rx, mask);
      int t;
      int gap;
      t = 0;
      gap = 0;
      wr_cfg(1'b0, cfg);
      repeat (3) begin
         @(negedge core_clk_in);
         while (frame_start_out !== 1'b1) @(negedge core_clk_in);
         gap = cyc - t;
         t = cyc;
      end
      sync_lvl = pcm_sync_out;
      check_eq(gap, exp_gap);
      check_eq(cap & mask, e_cap);
      check_eq(rx_sample_out.ch0 & mask, e_rx);
   endtask : scen

   initial begin
      logic [15:0] m;
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(negedge core_clk_in);
      check_eq(main_config_out, 32'h00800000);
      // All four formats, with the three slow rates spread over them; a frame is always 500 cycles.
      for (int i = 0; i < 4; i++) begin
         m = (i == 1) ? 16'hFFFF : (i == 0) ? 16'h1FFF : 16'h00FF;
         nbits = (i == 3) ? 6'h08 : 6'h10;
         scen({3'h0, 2'(i), 4'h1, i == 2, i == 0, 21'h0}, 500, tx_sample_in.ch0 & m, (i == 3 ? 16'h00A5 : 16'hC3A5) & m, m);
         check_eq(sync_lvl, 1'b1);
      end
      nbits = 6'h10;
      scen(32'h08800020, 500, rev16(tx_sample_in.ch0), rev16(16'hC3A5), 16'hFFFF);
      // The codec opens its slot at the sync rise, one bit ahead of a short-sync frame, so both words sit one bit off.
      scen(32'h08800004, 500, 16'h9B70, 16'h874A, 16'hFFFF);
      check_eq(sync_lvl, 1'b0);
      scen(32'h08800400, 500, 16'h0000, 16'hC3A5, 16'hFFFF);
      scen(32'h08800100, 500, 16'h0000, 16'h0000, 16'h0000);
      check_eq(sync_lvl, 1'b0);
      for (int r = 0; r < 2; r++) begin
         scen({24'h088000, r[0], 7'h40}, 500, tx_sample_in.ch0, 16'hC3A5, 16'hFFFF);
         repeat (50) @(negedge core_clk_in);
         check_eq(pcm_data_oe_out, 1'b1);
         repeat (300) @(negedge core_clk_in);
         check_eq(pcm_data_oe_out, 1'b0);
      end
      scen(32'h08800200, 500, {8'h00, tx_sample_in.ch1[7:0]}, 16'h00C3, 16'h00FF);
      check_eq(cap[15:8], tx_sample_in.ch0[7:0]);
      check_eq(rx_sample_out.ch1[7:0], 8'hA5);
      wr_cfg(1'b1, 32'h04080020);
      @(negedge core_clk_in);
      check_eq(low_jitter_config_out, 32'h04080020);
      // Limit 32, step 8: 8 cycles a bit; divider 4 gives 32 bits, so 256 cycles a frame.
      scen(32'h08801800, 256, tx_sample_in.ch0, 16'hC3A5, 16'hFFFF);
      scen(32'h08800802, 256, tx_sample_in.ch0, 16'hC3A5, 16'hFFFF);
      tally_and_finish();
   end
endmodule : pvp_voice_port_tb_top
